// >>> design/dbg_pin_setup.sv
// On-chip debug pin assignment, enable and break-source logic.
// Assumes fuses are static; pins come from outside and are synchronised here.
// Contract
// - Debug port active only when the enable fuse reads programmed (0).
// - With debug on, reset pin becomes debug clock input.
// - Exactly one pin becomes debug data, chosen by clock source.
// - RC oscillator: debug data on oscillator input pin.
// - External clock: clock on input pin, debug data on output pin.
// - Crystal: both oscillator pins for crystal, debug data on port3 bit7.
// - Interface-select fuse chooses normal or fast two-wire variant.
// - Breakpoint instruction halts execution while debug is enabled.
// - Debug off: breakpoint instruction is a two-cycle no-operation.
// - Four address comparators halt on a matching fetch address.
// - Also halt on flow change, stack error, watchdog, reset.
// - Debug on: port3 bit6 function and external reset are lost.
// - RC mode: port4 bit0 unavailable as general I/O.
// - External clock mode: port4 bit1 I/O and clock output lost.
// - Non-intrusive; link gives register/memory access and programming requests.
`timescale 1ns/10ps
`default_nettype none
module dbg_pin_setup
  import dbg_pin_pkg::*;
#(
  parameter int N_CMP = dbg_pin_pkg::NUM_CMP,
  parameter int AW = dbg_pin_pkg::ADDR_W
) (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic DEBUG_EN_FUSE_I,
  input wire logic IF_SEL_FUSE_I,
  input wire dbg_pin_pkg::clk_src_t CLK_SRC_I,
  input wire logic RST_PIN_I,
  input wire logic OSC_IN_PIN_I,
  input wire logic OSC_OUT_PIN_I,
  input wire logic P37_PIN_I,
  input wire dbg_pin_pkg::pin_drv_t P36_GPIO_I,
  input wire dbg_pin_pkg::pin_drv_t P37_GPIO_I,
  input wire dbg_pin_pkg::pin_drv_t P40_GPIO_I,
  input wire dbg_pin_pkg::pin_drv_t P41_GPIO_I,
  input wire logic CLOCK_OUT_EN_I,
  input wire logic CLOCK_OUT_I,
  input wire logic [AW-1:0] FETCH_ADDR_I,
  input wire logic FETCH_VLD_I,
  input wire logic BREAK_INSN_I,
  input wire dbg_pin_pkg::break_evt_t BREAK_EVT_I,
  input wire logic [N_CMP*AW-1:0] BP_ADDR_I,
  input wire logic [N_CMP-1:0] BP_EN_I,
  input wire logic DATA_OUT_I,
  input wire logic DATA_OE_N_I,
  output logic DEBUG_ACTIVE_O,
  output logic FAST_VARIANT_O,
  output logic EXT_RESET_EN_O,
  output logic EXT_RESET_O,
  output logic OSC_IN_IS_CLOCK_O,
  output logic OSC_OUT_ACTIVE_O,
  output dbg_pin_pkg::pin_drv_t P36_PAD_O,
  output dbg_pin_pkg::pin_drv_t P37_PAD_O,
  output dbg_pin_pkg::pin_drv_t P40_PAD_O,
  output dbg_pin_pkg::pin_drv_t P41_PAD_O,
  output logic [2:0] DATA_PIN_SEL_O,
  output logic HALT_O,
  output logic NOP_STALL_O,
  output logic [7:0] LINK_CMD_O,
  output logic LINK_CMD_VLD_O
);
  initial begin
    if (N_CMP < 1 || N_CMP > 8) $error("N_CMP out of range");
    if (AW < 1) $error("AW must be positive");
  end

  localparam pin_drv_t PIN_IDLE = '{o: 1'b1, oe_n: 1'b1};

  typedef struct packed {
    logic [1:0] dbg_clk_s;
    logic dbg_clk_d;
    logic [1:0] dat_s;
    logic [1:0] rst_s;
    logic en;
    logic fast;
    clk_src_t src;
    run_state_t run;
    logic nop_cnt;
    logic dbg_clk_edge;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;
  logic dat_raw;
  pin_drv_t link_drv;
  logic bp_hit;
  logic [7:0] cmd;
  logic cmd_vld;

  function automatic logic [2:0] data_pin_pick(input clk_src_t s);
    unique case (s)
      CLK_RC: data_pin_pick = 3'h1;
      CLK_EXT: data_pin_pick = 3'h2;
      CLK_XTAL: data_pin_pick = 3'h4;
      default: data_pin_pick = 3'h4;
    endcase
  endfunction

  // The pin is picked ahead of the synchroniser, so a source change costs only stale bits.
  always_comb begin
    unique case (data_pin_pick(st_ff.src))
      3'h1: dat_raw = OSC_IN_PIN_I;
      3'h2: dat_raw = OSC_OUT_PIN_I;
      default: dat_raw = P37_PIN_I;
    endcase
  end

  always_comb begin
    bp_hit = 1'b0;
    for (int i = 0; i < N_CMP; i++) begin
      if (BP_EN_I[i] && FETCH_ADDR_I == BP_ADDR_I[i*AW +: AW]) begin
        bp_hit = 1'b1;
      end
    end
  end

  dbg_link_shift #(
    .CMD_W(CMD_W)
  ) u_shift (
    .clk_i(CLK_SYS_I),
    .rstn_i(RSTN_I),
    .clr_i(!st_ff.en),
    .edge_i(st_ff.dbg_clk_edge),
    .bit_i(st_ff.dat_s[1]),
    .cmd_o(cmd),
    .cmd_vld_o(cmd_vld)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.dbg_clk_s = {st_ff.dbg_clk_s[0], RST_PIN_I};
    nxt_st.dat_s = {st_ff.dat_s[0], dat_raw};
    nxt_st.rst_s = {st_ff.rst_s[0], RST_PIN_I};
    nxt_st.dbg_clk_d = st_ff.dbg_clk_s[1];
    nxt_st.dbg_clk_edge = st_ff.dbg_clk_s[1] && !st_ff.dbg_clk_d && st_ff.en;
    nxt_st.en = (DEBUG_EN_FUSE_I == FUSE_PROGRAMMED);
    nxt_st.fast = (IF_SEL_FUSE_I == FUSE_PROGRAMMED);
    nxt_st.src = CLK_SRC_I;
    unique case (st_ff.run)
      RUN: begin
        if (st_ff.en) begin
          if ((FETCH_VLD_I && (BREAK_INSN_I || bp_hit)) || (|BREAK_EVT_I) ||
              (cmd_vld && cmd == CMD_HALT)) begin
            nxt_st.run = HALTED;
          end
        end else if (FETCH_VLD_I && BREAK_INSN_I) begin
          nxt_st.run = NOP_EXEC;
          nxt_st.nop_cnt = 1'(NOP_CYCLES - 1);
        end
      end
      HALTED: begin
        if (!st_ff.en || (cmd_vld && cmd == CMD_RESUME)) begin
          nxt_st.run = RUN;
        end
      end
      NOP_EXEC: begin
        if (st_ff.nop_cnt == 1'b0) begin
          nxt_st.run = RUN;
        end else begin
          nxt_st.nop_cnt = 1'b0;
        end
      end
      default: nxt_st.run = RUN;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      // Delayed clock copy resets high, so no false rising edge can follow reset.
      st_ff <= '{dbg_clk_s: 2'h3, dbg_clk_d: 1'b1, dat_s: 2'h3, rst_s: 2'h3, en: 1'b0,
                 fast: 1'b0, src: CLK_RC, run: RUN, nop_cnt: 1'b0, dbg_clk_edge: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    DATA_PIN_SEL_O = st_ff.en ? data_pin_pick(st_ff.src) : 3'h0;
    P36_PAD_O = st_ff.en ? PIN_IDLE : P36_GPIO_I;
    EXT_RESET_EN_O = !st_ff.en;
    EXT_RESET_O = !st_ff.en && !st_ff.rst_s[1];
    P40_PAD_O = (st_ff.en && DATA_PIN_SEL_O[0]) ? link_drv : P40_GPIO_I;
    if (st_ff.en && DATA_PIN_SEL_O[1]) begin
      P41_PAD_O = link_drv;
    end else if (CLOCK_OUT_EN_I) begin
      P41_PAD_O = pin_drv_t'{o: CLOCK_OUT_I, oe_n: 1'b0};
    end else begin
      P41_PAD_O = P41_GPIO_I;
    end
    P37_PAD_O = (st_ff.en && DATA_PIN_SEL_O[2]) ? link_drv : P37_GPIO_I;
    OSC_IN_IS_CLOCK_O = (st_ff.src != CLK_RC);
    OSC_OUT_ACTIVE_O = (st_ff.src == CLK_XTAL);
  end

  assign link_drv = '{o: DATA_OUT_I, oe_n: DATA_OE_N_I};
  assign DEBUG_ACTIVE_O = st_ff.en;
  assign FAST_VARIANT_O = st_ff.en && st_ff.fast;
  assign HALT_O = (st_ff.run == HALTED);
  assign NOP_STALL_O = (st_ff.run == NOP_EXEC);
  assign LINK_CMD_O = cmd;
  assign LINK_CMD_VLD_O = cmd_vld && st_ff.en;
endmodule : dbg_pin_setup
`default_nettype wire

// >>> design/dbg_pin_pkg.sv
// Package for the on-chip debug pin setup and break-source logic.
// Assumes a single system clock; fuses are stable static levels.
package dbg_pin_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // Period of the debug clock in the bench, used only for sizing checks.
  localparam int DCLK_PERIOD_NS = 800;
  localparam int DCLK_CYCLES = (DCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NOP_CYCLES = 2;
  localparam int NUM_CMP = 4;
  localparam int ADDR_W = 16;
  localparam int CMD_W = 8;
  localparam int CNT_W = 2;
  // Fuse levels: programmed is 0.
  localparam logic FUSE_PROGRAMMED = 1'b0;
  // Link command codes shifted in on the data pin.
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_RESUME = 8'h01;
  localparam logic [7:0] CMD_HALT = 8'h02;
  localparam logic [7:0] CMD_RMW = 8'h03;
  localparam logic [7:0] CMD_PROG = 8'h04;

  typedef enum logic [1:0] {
    CLK_RC = 2'b00,
    CLK_EXT = 2'b01,
    CLK_XTAL = 2'b10
  } clk_src_t;

  typedef enum logic [1:0] {
    RUN = 2'b00,
    HALTED = 2'b01,
    NOP_EXEC = 2'b10
  } run_state_t;

  typedef struct packed {
    logic o;
    logic oe_n;
  } pin_drv_t;

  typedef struct packed {
    logic flow_change;
    logic stack_err;
    logic wdt_ovf;
    logic reset_evt;
  } break_evt_t;
endpackage : dbg_pin_pkg

// >>> design/dbg_link_shift.sv
// Shift register that assembles command bytes from the debug data pin.
// Assumes the debug clock rising edge arrives as a one-cycle pulse on CLK_SYS_I.
`timescale 1ns/10ps
`default_nettype none
module dbg_link_shift #(
  parameter int CMD_W = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  input wire logic edge_i,
  input wire logic bit_i,
  output logic [CMD_W-1:0] cmd_o,
  output logic cmd_vld_o
);
  typedef struct packed {
    logic [CMD_W-1:0] sh;
    logic [$clog2(CMD_W):0] cnt;
    logic [CMD_W-1:0] cmd;
    logic vld;
  } sh_state_t;

  sh_state_t st_ff;
  sh_state_t nxt_st;

  initial begin
    if (CMD_W < 2) $error("CMD_W too small");
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.vld = 1'b0;
    if (clr_i) begin
      nxt_st.cnt = '0;
    end else if (edge_i) begin
      nxt_st.sh = {st_ff.sh[CMD_W-2:0], bit_i};
      if (st_ff.cnt == ($clog2(CMD_W)+1)'(CMD_W - 1)) begin
        nxt_st.cnt = '0;
        nxt_st.cmd = {st_ff.sh[CMD_W-2:0], bit_i};
        nxt_st.vld = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cmd_o = st_ff.cmd;
  assign cmd_vld_o = st_ff.vld;
endmodule : dbg_link_shift
`default_nettype wire

// >>> sim/dbg_pin_chk.sv
// Checker on the debug pin setup ports.
// Assumes fuses and clock source change only under reset.
`timescale 1ns/10ps
`default_nettype none
module dbg_pin_chk (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic FETCH_VLD_I,
  input wire logic BREAK_INSN_I,
  input wire logic DEBUG_ACTIVE_O,
  input wire logic EXT_RESET_EN_O,
  input wire logic OSC_IN_IS_CLOCK_O,
  input wire logic OSC_OUT_ACTIVE_O,
  input wire dbg_pin_pkg::pin_drv_t P36_PAD_O,
  input wire logic [2:0] DATA_PIN_SEL_O,
  input wire logic HALT_O,
  input wire logic NOP_STALL_O,
  input wire logic LINK_CMD_VLD_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  property p_off; !DEBUG_ACTIVE_O |-> DATA_PIN_SEL_O == 3'h0 && EXT_RESET_EN_O; endproperty
  a_off: assert property (p_off) else $error("pin taken");
  property p_on; DEBUG_ACTIVE_O |-> !EXT_RESET_EN_O && P36_PAD_O.oe_n; endproperty
  a_on: assert property (p_on) else $error("reset kept");
  property p_one; DEBUG_ACTIVE_O |-> $onehot(DATA_PIN_SEL_O); endproperty
  a_one: assert property (p_one) else $error("not one pin");
  property p_rc; DEBUG_ACTIVE_O && !OSC_IN_IS_CLOCK_O |-> DATA_PIN_SEL_O == 3'h1; endproperty
  a_rc: assert property (p_rc) else $error("rc pin");
  property p_ext;
    DEBUG_ACTIVE_O && OSC_IN_IS_CLOCK_O && !OSC_OUT_ACTIVE_O |-> DATA_PIN_SEL_O == 3'h2;
  endproperty
  a_ext: assert property (p_ext) else $error("external clock pin");
  property p_xt; DEBUG_ACTIVE_O && OSC_OUT_ACTIVE_O |-> DATA_PIN_SEL_O == 3'h4; endproperty
  a_xt: assert property (p_xt) else $error("crystal pin");
  property p_nop; $rose(NOP_STALL_O) |-> NOP_STALL_O[*2] ##1 !NOP_STALL_O; endproperty
  a_nop: assert property (p_nop) else $error("stall length");
  property p_brk;
    DEBUG_ACTIVE_O && FETCH_VLD_I && BREAK_INSN_I && !HALT_O && !NOP_STALL_O |=> HALT_O;
  endproperty
  a_brk: assert property (p_brk) else $error("no halt");
  property p_hold;
    HALT_O && DEBUG_ACTIVE_O && !LINK_CMD_VLD_O && !$past(LINK_CMD_VLD_O) |=> HALT_O;
  endproperty
  a_hold: assert property (p_hold) else $error("halt lost");
endmodule // dbg_pin_chk
bind dbg_pin_setup dbg_pin_chk i_chk (.CLK_SYS_I, .RSTN_I, .FETCH_VLD_I, .BREAK_INSN_I,
  .DEBUG_ACTIVE_O, .EXT_RESET_EN_O, .OSC_IN_IS_CLOCK_O, .OSC_OUT_ACTIVE_O, .P36_PAD_O,
  .DATA_PIN_SEL_O, .HALT_O, .NOP_STALL_O, .LINK_CMD_VLD_O);
`default_nettype wire

// >>> sim/dbg_emu.sv
// Emulator model: debug clock and data bytes.
// Assumes the bench routes the data line to the picked pin.
`timescale 1ns/10ps
`default_nettype none
module dbg_emu (
  output logic dclk_o,
  output logic dda_o
);
  initial {dclk_o, dda_o} = 2'h0;
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      dda_o = b[i];
      #400 dclk_o = 1'b1;
      #400 dclk_o = 1'b0;
    end
    // The released line flips so that a late sample cannot pass.
    dda_o = ~b[0];
  endtask
endmodule // dbg_emu
`default_nettype wire

// >>> sim/testbench.sv
// Bench for the debug pin setup block.
// Assumes the emulator model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dbg_pin_pkg::*;
  logic clk = 0, rstn = 0, en = 1, ifs = 1, fv = 0, bi = 0, ck = 0, rpin = 1, dc, dd;
  logic act, fast, rste, rsto, oic, ooa, halt, nop, vld;
  logic [1:0] g = 2'h2, dq = 2'h1, p36, p37, p40, p41;
  logic [2:0] sel;
  logic [3:0] ev = 4'h0;
  logic [7:0] cmd;
  logic [15:0] fa = 16'h0;
  clk_src_t src = CLK_RC;
  int num_errors = 0, checked = 0, cyc = 0, nn = 0, nv = 0;
  always #50 clk = ~clk;
  always @(negedge clk) begin
    nn += nop;
    nv += vld;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  dbg_emu i_emu (.dclk_o(dc), .dda_o(dd));
  dbg_pin_setup i_dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .DEBUG_EN_FUSE_I(en), .IF_SEL_FUSE_I(ifs),
    .CLK_SRC_I(src), .RST_PIN_I(en ? rpin : dc), .OSC_IN_PIN_I(dd ^ (src != CLK_RC)),
    .OSC_OUT_PIN_I(dd ^ (src != CLK_EXT)), .P37_PIN_I(dd ^ (src != CLK_XTAL)),
    .P36_GPIO_I(g), .P37_GPIO_I(g), .P40_GPIO_I(g), .P41_GPIO_I(g), .CLOCK_OUT_EN_I(ck),
    .CLOCK_OUT_I(1'b0), .FETCH_ADDR_I(fa), .FETCH_VLD_I(fv), .BREAK_INSN_I(bi),
    .BREAK_EVT_I(ev), .BP_ADDR_I(64'h0104_0103_0102_0101), .BP_EN_I(4'hF),
    .DATA_OUT_I(dq[1]), .DATA_OE_N_I(dq[0]), .DEBUG_ACTIVE_O(act), .FAST_VARIANT_O(fast),
    .EXT_RESET_EN_O(rste), .EXT_RESET_O(rsto), .OSC_IN_IS_CLOCK_O(oic),
    .OSC_OUT_ACTIVE_O(ooa), .P36_PAD_O(p36), .P37_PAD_O(p37), .P40_PAD_O(p40),
    .P41_PAD_O(p41), .DATA_PIN_SEL_O(sel), .HALT_O(halt),
    .NOP_STALL_O(nop), .LINK_CMD_O(cmd), .LINK_CMD_VLD_O(vld));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input int e, input int s);
    @(negedge clk);
    rstn = 0;
    en = e[0];
    ifs = s[0];
    src = clk_src_t'(s);
    repeat (16) @(negedge clk);
    rstn = 1;
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse(input int k);
    @(negedge clk);
    fa = 16'h0100 + 16'(k);
    fv = k < 5;
    bi = k == 0;
    ev = 4'(k > 4 ? 1 << (k - 5) : 0);
    @(negedge clk);
    {fv, bi, ev} = 6'h0;
  endtask
  task automatic t_pins(input int e, input int s);
    ck = !e;
    cfg(e, s);
    chk(sel, e ? 3'h0 : 3'h1 << s);
    chk({act, rste, rsto, oic, ooa}, {!e[0], e[0], 1'b0, s != 0, s == 2});
    chk({p36, p37}, {e ? g : 2'h3, e || s < 2 ? g : dq});
    if (s == 0) chk(p40, e ? g : dq);
    if (s == 1) chk(p41, e ? g : dq);
    chk(fast, !e && !s[0]);
    rpin = 0;
    repeat (3) @(negedge clk);
    chk(rsto, e[0]);
    rpin = 1;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_link();
    int v;
    cfg(0, 0);
    v = nv;
    i_emu.send(CMD_HALT);
    repeat (8) @(negedge clk);
    chk(halt, 1'b1);
    i_emu.send(CMD_PROG);
    repeat (8) @(negedge clk);
    chk(cmd, CMD_PROG);
    chk(8'(nv - v), 8'h2);
    chk(halt, 1'b1);
    i_emu.send(CMD_RESUME);
    repeat (8) @(negedge clk);
    chk(halt, 1'b0);
  endtask
  task automatic brk(input int k);
    pulse(k);
    @(negedge clk);
    chk(halt, 1'b1);
    i_emu.send(CMD_RMW);
    repeat (8) @(negedge clk);
    chk(cmd, CMD_RMW);
    chk(halt, 1'b1);
    i_emu.send(CMD_RESUME);
    repeat (8) @(negedge clk);
    chk(halt, 1'b0);
  endtask
  task automatic t_nop();
    int n;
    cfg(1, 0);
    pulse(1);
    n = nn;
    pulse(0);
    repeat (6) @(negedge clk);
    chk(8'(nn - n), 8'h2);
    chk(halt, 1'b0);
  endtask
  task automatic summarize();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 6; i++) t_pins(i / 3, i % 3);
    t_nop();
    t_link();
    for (int i = 0; i < 27; i++) begin
      if (i % 9 == 0) cfg(0, i / 9);
      brk(i % 9);
    end
    summarize();
  end
endmodule // testbench
`default_nettype wire
